// >>> src/csie_pkg.sv
// Constants and types shared by the card socket interrupt event block.
package csie_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned SER_SLOT_NS   = 32;
	localparam int unsigned SER_SLOT_CYC  = SER_SLOT_NS / CLK_PERIOD_NS;
	localparam int unsigned SER_SLOTS     = 16;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] LEG_FLAG_OFS  = 8'h04;
	localparam logic [7:0] LEG_MASK_OFS  = 8'h05;
	localparam logic [7:0] LEG_GCTRL_OFS = 8'h1e;
	localparam logic [7:0] FUNC_STAT_OFS = 8'h91;
	localparam logic [7:0] ROUTE_OFS     = 8'h92;
	localparam logic [7:0] SOCK_EVT_OFS  = 8'h00;
	localparam logic [7:0] SOCK_MASK_OFS = 8'h04;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned LEG_BATT1_BIT   = 0;
	localparam int unsigned LEG_BATT2_BIT   = 1;
	localparam int unsigned LEG_READY_BIT   = 2;
	localparam int unsigned LEG_IO_CARD_STATUS_CHANGE_BIT  = 0;
	localparam int unsigned LEG_PWR_BIT     = 3;
	localparam int unsigned GCTRL_CLR_BIT   = 2;
	localparam int unsigned SOCK_STAT_BIT   = 0;
	localparam int unsigned SOCK_CD1_BIT    = 1;
	localparam int unsigned SOCK_CD2_BIT    = 2;
	localparam int unsigned SOCK_PWR_BIT    = 3;
	localparam int unsigned FUNC_STAT_BIT   = 0;
	localparam int unsigned RT_PCI_BIT      = 0;
	localparam int unsigned RT_MODE_LSB     = 1;
	localparam int unsigned RT_CSC_TERM_LSB = 4;
	localparam int unsigned RT_FUNC_TERM_LSB = 8;
	localparam int unsigned RT_CSC_IRQ_LSB  = 16;
	localparam int unsigned RT_FUNC_IRQ_LSB = 20;
	localparam int unsigned NUM_FLAGS       = 4;
	localparam int unsigned NUM_TERM        = 7;
	localparam logic [2:0]  SER_TERM        = 3'h6;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [3:0]  FLAGS_RST = 4'h0;
	localparam logic [7:0]  MASK_RST  = 8'h00;
	localparam logic [7:0]  GCTRL_RST = 8'h00;
	localparam logic [31:0] ROUTE_RST = 32'h0000_0001;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {CARD_MEM16, CARD_IO16, CARD_CB32}
		csie_card_t;
	typedef enum logic [1:0] {SCH_NONE, SCH_PAR_IRQ, SCH_SERIAL}
		csie_sch_t;
	typedef enum logic [1:0] {SP_LEGACY, SP_CONFIG, SP_SOCKET}
		csie_space_t;

endpackage

// >>> src/csie_flag_if.sv
// Set, clear and flag signals of one bank of sticky event flags.
`timescale 1ns/1ns
interface csie_flag_if #(parameter int unsigned N = 4);
	logic [N-1:0] set;
	logic [N-1:0] clr;
	logic [N-1:0] flags;
	modport bank (input set, input clr, output flags);
	modport ctrl (output set, output clr, input flags);
endinterface

// >>> src/csie_flag_bank.sv
// Bank of sticky event flags where a set beats a clear.
`timescale 1ns/1ns
module csie_flag_bank #(parameter int unsigned N = 4) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Flag bank
	csie_flag_if.bank f
);
	always_ff @(posedge clk) begin
		if (rst) begin
			f.flags <= N'(csie_pkg::FLAGS_RST);
		end else begin
			f.flags <= (f.flags & ~f.clr) | f.set;
		end
	end
endmodule // csie_flag_bank

// >>> src/csie_ser_irq.sv
// Serialized IRQ frame generator: start slot, sixteen IRQ slots, stop.
`timescale 1ns/1ns
module csie_ser_irq (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Control and data
	input wire logic        en,
	input wire logic [15:0] irq_vec,
	// Serial line, high means the line is pulled to its active level
	output logic            ser_out
);
	typedef enum {ST_START, ST_DATA, ST_STOP} csie_ser_state_t;

	csie_ser_state_t state_reg;
	logic [7:0]      div_reg;
	logic [3:0]      idx_reg;
	logic            slot_en;

	assign slot_en = (div_reg == 8'(csie_pkg::SER_SLOT_CYC - 1));

	always_ff @(posedge clk) begin
		if (rst || !en || slot_en) begin
			div_reg <= 8'h00;
		end else begin
			div_reg <= div_reg + 8'h01;
		end
	end

	// The IRQ vector is sampled slot by slot, so a request that comes
	// and goes between its slots is not seen in that frame.
	always_ff @(posedge clk) begin
		if (rst || !en) begin
			state_reg <= ST_START;
			idx_reg   <= 4'h0;
			ser_out   <= 1'b0;
		end else if (slot_en) begin
			case (state_reg)
				ST_START: begin
					ser_out   <= 1'b1;
					idx_reg   <= 4'h0;
					state_reg <= ST_DATA;
				end
				ST_DATA: begin
					ser_out <= irq_vec[idx_reg];
					idx_reg <= idx_reg + 4'h1;
					if (idx_reg == 4'(csie_pkg::SER_SLOTS - 1)) begin
						state_reg <= ST_STOP;
					end
				end
				default: begin
					ser_out   <= 1'b0;
					state_reg <= ST_START;
				end
			endcase
		end
	end
endmodule // csie_ser_irq

// >>> src/csie_top.sv
// Card socket interrupt events: flags, masks, routing to host terminals.
// Operation
// RULE1 - Sources split into status-change or functional classes
// RULE2 - All host signaling leaves through seven terminals
// RULE3 - Parallel bus, parallel IRQ and serial IRQ schemes
// RULE4 - Memory card battery transitions set flags 1,0
// RULE5 - Memory card ready transition sets flag 2
// RULE6 - I/O card status-change assertion sets flag 0
// RULE7 - I/O card request unmasked, status at 91h
// RULE8 - Bus card interrupt unmasked, status at 91h
// RULE9 - Bus card status-change sets socket event 0
// RULE10 - Card detect transitions set socket events 2,1
// RULE11 - Power-up completion sets flag 3 per card
// RULE12 - No functional interrupt for memory cards
// RULE13 - Shared pins interpreted by inserted card type
// RULE14 - Legacy flags clear on read or write-one
// RULE15 - Socket events cleared by writing one
// RULE16 - Flags sticky; request ORs enabled flags, functional
`timescale 1ns/1ns
module csie_top (
	// Clock and reset
	input wire logic        REF_CLK,
	input wire logic        SYS_RST,
	// Socket pins and internal power event
	input wire logic [1:0]  PIN_CARD_TYPE,
	input wire logic        PIN_STAT_BATT_ONE,
	input wire logic        PIN_SPKR_BATT_TWO,
	input wire logic        PIN_IRQ_READY,
	input wire logic        PIN_CARD_DETECT_ONE,
	input wire logic        PIN_CARD_DETECT_TWO,
	input wire logic        POWER_CYCLE_DONE,
	// Register port
	input wire logic [1:0]  REG_SPACE,
	input wire logic [7:0]  REG_ADDR,
	input wire logic        REG_WR,
	input wire logic        REG_RD,
	input wire logic [31:0] REG_WDATA,
	output logic     [31:0] REG_RDATA,
	output logic            REG_ACK,
	// Host interrupt terminals
	output logic     [6:0]  MF_TERM
);
	// ----------------------------------------------------------------
	// Card type and pin edges
	// ----------------------------------------------------------------
	csie_pkg::csie_card_t card;
	logic is_mem, is_io, is_cb, is_16;
	logic stat_prev_reg, batt2_prev_reg, ready_prev_reg;
	logic cd1_prev_reg, cd2_prev_reg;
	logic stat_edge, stat_rise, batt2_edge, ready_edge, cd1_edge, cd2_edge;

	assign card   = csie_pkg::csie_card_t'(PIN_CARD_TYPE);
	assign is_mem = (card == csie_pkg::CARD_MEM16); // RULE13
	assign is_io  = (card == csie_pkg::CARD_IO16); // RULE13
	assign is_cb  = (card == csie_pkg::CARD_CB32); // RULE13
	assign is_16  = is_mem || is_io;

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			stat_prev_reg  <= 1'b0;
			batt2_prev_reg <= 1'b0;
			ready_prev_reg <= 1'b0;
			cd1_prev_reg   <= 1'b0;
			cd2_prev_reg   <= 1'b0;
		end else begin
			stat_prev_reg  <= PIN_STAT_BATT_ONE;
			batt2_prev_reg <= PIN_SPKR_BATT_TWO;
			ready_prev_reg <= PIN_IRQ_READY;
			cd1_prev_reg   <= PIN_CARD_DETECT_ONE;
			cd2_prev_reg   <= PIN_CARD_DETECT_TWO;
		end
	end

	assign stat_edge  = PIN_STAT_BATT_ONE ^ stat_prev_reg;
	assign stat_rise  = PIN_STAT_BATT_ONE & ~stat_prev_reg;
	assign batt2_edge = PIN_SPKR_BATT_TWO ^ batt2_prev_reg;
	assign ready_edge = PIN_IRQ_READY ^ ready_prev_reg;
	assign cd1_edge   = PIN_CARD_DETECT_ONE ^ cd1_prev_reg;
	assign cd2_edge   = PIN_CARD_DETECT_TWO ^ cd2_prev_reg;

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	logic [7:0]  leg_mask_reg;
	logic [7:0]  gctrl_reg;
	logic [3:0]  sock_mask_reg;
	logic [31:0] route_reg;
	logic        leg_hit, sock_hit, cfg_hit;

	assign leg_hit  = (REG_SPACE == 2'(csie_pkg::SP_LEGACY));
	assign cfg_hit  = (REG_SPACE == 2'(csie_pkg::SP_CONFIG));
	assign sock_hit = (REG_SPACE == 2'(csie_pkg::SP_SOCKET));

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			leg_mask_reg  <= csie_pkg::MASK_RST;
			gctrl_reg     <= csie_pkg::GCTRL_RST;
			sock_mask_reg <= csie_pkg::MASK_RST[3:0];
			route_reg     <= csie_pkg::ROUTE_RST;
		end else if (REG_WR) begin
			if (leg_hit && REG_ADDR == csie_pkg::LEG_MASK_OFS) begin
				leg_mask_reg <= REG_WDATA[7:0];
			end else if (leg_hit && REG_ADDR == csie_pkg::LEG_GCTRL_OFS) begin
				gctrl_reg <= REG_WDATA[7:0];
			end else if (sock_hit && REG_ADDR == csie_pkg::SOCK_MASK_OFS) begin
				sock_mask_reg <= REG_WDATA[3:0];
			end else if (cfg_hit && REG_ADDR == csie_pkg::ROUTE_OFS) begin
				route_reg <= REG_WDATA;
			end
		end
	end

	// ----------------------------------------------------------------
	// Event flag banks
	// ----------------------------------------------------------------
	csie_flag_if #(.N(csie_pkg::NUM_FLAGS)) leg_if ();
	csie_flag_if #(.N(csie_pkg::NUM_FLAGS)) sock_if ();
	logic clr_by_write, leg_flag_wr, leg_flag_rd, sock_evt_wr;

	assign clr_by_write = gctrl_reg[csie_pkg::GCTRL_CLR_BIT];
	assign leg_flag_wr  = REG_WR && leg_hit && REG_ADDR == csie_pkg::LEG_FLAG_OFS;
	assign leg_flag_rd  = REG_RD && leg_hit && REG_ADDR == csie_pkg::LEG_FLAG_OFS;
	assign sock_evt_wr  = REG_WR && sock_hit
		&& REG_ADDR == csie_pkg::SOCK_EVT_OFS;

	// Status-change class: every set term below is a detected event.
	assign leg_if.set[csie_pkg::LEG_BATT1_BIT] = (is_mem && stat_edge) // RULE4
		|| (is_io && stat_rise); // RULE6
	assign leg_if.set[csie_pkg::LEG_BATT2_BIT] = is_mem && batt2_edge; // RULE4
	assign leg_if.set[csie_pkg::LEG_READY_BIT] = is_mem && ready_edge; // RULE5
	assign leg_if.set[csie_pkg::LEG_PWR_BIT] = is_16 && POWER_CYCLE_DONE; // RULE11

	// Unless write-one clear is selected, a read clears every flag it returned; the read data is captured in
	// the same cycle, so no flag is lost between read and clear.
	assign leg_if.clr = clr_by_write ? (leg_flag_wr ? REG_WDATA[3:0] : 4'h0)
		: (leg_flag_rd ? 4'hf : 4'h0); // RULE14

	assign sock_if.set[csie_pkg::SOCK_STAT_BIT] = is_cb && stat_rise; // RULE9
	assign sock_if.set[csie_pkg::SOCK_CD1_BIT] = cd1_edge; // RULE10
	assign sock_if.set[csie_pkg::SOCK_CD2_BIT] = cd2_edge; // RULE10
	assign sock_if.set[csie_pkg::SOCK_PWR_BIT] = is_cb
		&& POWER_CYCLE_DONE; // RULE11
	assign sock_if.clr = sock_evt_wr ? REG_WDATA[3:0] : 4'h0; // RULE15

	csie_flag_bank #(.N(csie_pkg::NUM_FLAGS)) u_leg_bank (
		.clk (REF_CLK),
		.rst (SYS_RST),
		.f   (leg_if)
	); // RULE16
	csie_flag_bank #(.N(csie_pkg::NUM_FLAGS)) u_sock_bank (
		.clk (REF_CLK),
		.rst (SYS_RST),
		.f   (sock_if)
	); // RULE16

	// ----------------------------------------------------------------
	// Interrupt classes
	// ----------------------------------------------------------------
	logic func_req, csc_req;

	// Functional requests pass with no mask and are never latched.
	assign func_req = (is_io || is_cb) && PIN_IRQ_READY; // RULE7 RULE8 RULE12
	assign csc_req  = |(leg_if.flags & leg_mask_reg[3:0])
		|| |(sock_if.flags & sock_mask_reg); // RULE1 RULE16

	// ----------------------------------------------------------------
	// Host signaling
	// ----------------------------------------------------------------
	csie_pkg::csie_sch_t scheme;
	logic [2:0]  csc_term, func_term;
	logic [3:0]  csc_irq, func_irq;
	logic [15:0] irq_vec;
	logic        ser_bit;
	logic [6:0]  term_next;

	assign scheme    = csie_pkg::csie_sch_t'(
		route_reg[csie_pkg::RT_MODE_LSB +: 2]);
	assign csc_term  = route_reg[csie_pkg::RT_CSC_TERM_LSB +: 3];
	assign func_term = route_reg[csie_pkg::RT_FUNC_TERM_LSB +: 3];
	assign csc_irq   = route_reg[csie_pkg::RT_CSC_IRQ_LSB +: 4];
	assign func_irq  = route_reg[csie_pkg::RT_FUNC_IRQ_LSB +: 4];

	always_comb begin
		irq_vec = 16'h0000;
		irq_vec[csc_irq] = csc_req;
		irq_vec[func_irq] = irq_vec[func_irq] | func_req;
	end

	csie_ser_irq u_ser (
		.clk     (REF_CLK),
		.rst     (SYS_RST),
		.en      (scheme == csie_pkg::SCH_SERIAL),
		.irq_vec (irq_vec),
		.ser_out (ser_bit)
	); // RULE3

	// Parallel bus interrupt on terminal 0 may be combined with either
	// of the other schemes; a terminal index of 7 selects no terminal.
	always_comb begin
		term_next = 7'h00;
		if (route_reg[csie_pkg::RT_PCI_BIT]) begin
			term_next[0] = csc_req || func_req; // RULE3
		end
		if (scheme == csie_pkg::SCH_PAR_IRQ) begin
			if (csc_term < 3'(csie_pkg::NUM_TERM)) begin
				term_next[csc_term] = term_next[csc_term] | csc_req;
			end
			if (func_term < 3'(csie_pkg::NUM_TERM)) begin
				term_next[func_term] = term_next[func_term] | func_req;
			end
		end else if (scheme == csie_pkg::SCH_SERIAL) begin
			term_next[csie_pkg::SER_TERM] = term_next[csie_pkg::SER_TERM]
				| ser_bit; // RULE3
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			MF_TERM <= 7'h00;
		end else begin
			MF_TERM <= term_next; // RULE2
		end
	end

	// ----------------------------------------------------------------
	// Register read path
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			REG_RDATA <= 32'h0000_0000;
			REG_ACK   <= 1'b0;
		end else begin
			REG_ACK <= REG_RD || REG_WR;
			if (!REG_RD) begin
				REG_RDATA <= 32'h0000_0000;
			end else if (leg_hit && REG_ADDR == csie_pkg::LEG_FLAG_OFS) begin
				REG_RDATA <= {28'h0, leg_if.flags};
			end else if (leg_hit && REG_ADDR == csie_pkg::LEG_MASK_OFS) begin
				REG_RDATA <= {24'h0, leg_mask_reg};
			end else if (leg_hit && REG_ADDR == csie_pkg::LEG_GCTRL_OFS) begin
				REG_RDATA <= {24'h0, gctrl_reg};
			end else if (cfg_hit && REG_ADDR == csie_pkg::FUNC_STAT_OFS) begin
				REG_RDATA <= {31'h0, func_req}; // RULE7 RULE8
			end else if (cfg_hit && REG_ADDR == csie_pkg::ROUTE_OFS) begin
				REG_RDATA <= route_reg;
			end else if (sock_hit && REG_ADDR == csie_pkg::SOCK_EVT_OFS) begin
				REG_RDATA <= {28'h0, sock_if.flags};
			end else if (sock_hit && REG_ADDR == csie_pkg::SOCK_MASK_OFS) begin
				REG_RDATA <= {28'h0, sock_mask_reg};
			end else begin
				REG_RDATA <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_batt_edge_flag: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		is_mem && batt2_edge |=> leg_if.flags[1]) // RULE4
		else $error("battery two transition did not set flag 1");
	a_ready_edge_flag: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		is_mem && ready_edge |=> leg_if.flags[2]) // RULE5
		else $error("ready transition did not set flag 2");
	a_io_io_card_status_change_flag: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		is_io && $rose(PIN_STAT_BATT_ONE) |=> leg_if.flags[0]) // RULE6
		else $error("io status change did not set flag 0");
	a_func_status_read: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		REG_RD && cfg_hit && REG_ADDR == csie_pkg::FUNC_STAT_OFS
		|=> REG_ACK && REG_RDATA[0] == $past(func_req)) // RULE7
		else $error("functional status read mismatch");
	a_mem_no_func: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		is_mem |-> !func_req) // RULE12
		else $error("functional request seen for memory card");
	a_cb_io_card_status_change_flag: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		is_cb && $rose(PIN_STAT_BATT_ONE) |=> sock_if.flags[0]) // RULE9
		else $error("bus card status change did not set event 0");
	a_detect_one_flag: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		cd1_edge |=> sock_if.flags[1]) // RULE10
		else $error("card detect one transition did not set event 1");
	a_detect_two_flag: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		cd2_edge |=> sock_if.flags[2]) // RULE10
		else $error("card detect two transition did not set event 2");
	a_power_leg_flag: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		POWER_CYCLE_DONE && is_16 |=> leg_if.flags[3]) // RULE11
		else $error("power cycle complete legacy flag not set");
	a_power_cb_flag: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		POWER_CYCLE_DONE && is_cb |=> sock_if.flags[3]) // RULE11
		else $error("power cycle complete socket event not set");
	a_read_clears: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		leg_flag_rd && !clr_by_write && leg_if.set == 4'h0
		|=> leg_if.flags == 4'h0) // RULE14
		else $error("legacy flags not cleared by read");
	a_w1c_socket: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		sock_evt_wr && REG_WDATA[1] && !cd1_edge |=> !sock_if.flags[1]) // RULE15
		else $error("socket event not cleared by write one");
	a_irq_to_host: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		route_reg[0] && csc_req ##1 route_reg[0] |-> MF_TERM[0]) // RULE16
		else $error("enabled flag did not reach terminal 0");
	a_cb_func_unmasked: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		route_reg[0] && is_cb && PIN_IRQ_READY |=> MF_TERM[0]) // RULE8
		else $error("bus card interrupt did not reach terminal 0");
	a_flag_sticky: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
		leg_if.flags[0] && !leg_if.clr[0] |=> leg_if.flags[0]) // RULE16
		else $error("legacy flag 0 dropped without a clear");

endmodule // csie_top

// >>> bench/csie_card_model.sv
// Inserted card model: card type and the shared socket pin levels.
`timescale 1ns/1ns
module csie_card_model (
	// Clock
	input wire logic  clk,
	// Socket pins
	output logic [1:0] card_type,
	output logic [4:0] pins
);
	// ----------------------------------------------------------------
	// Pin driver
	// ----------------------------------------------------------------
	// Pins start low, so the release of reset sees no transition.
	initial begin
		card_type = 2'h3;
		pins      = 5'h00;
	end

	// Bit 0 is battery one or status, 1 battery two, 2 ready or request,
	// 3 and 4 the two detect pins; their meaning follows the card type.
	task automatic insert(input logic [1:0] t);
		@(negedge clk);
		card_type = t;
	endtask

	// Levels change only after a falling edge, clear of the sampling edge.
	task automatic drive(input int unsigned pin, input logic v);
		@(negedge clk);
		pins[pin] = v;
	endtask
endmodule // csie_card_model

// >>> bench/tb_top.sv
// Self-checking bench for the card socket interrupt event block.
`timescale 1ns/1ns
module tb_top;
	localparam logic [1:0] LG = csie_pkg::SP_LEGACY;
	localparam logic [1:0] CF = csie_pkg::SP_CONFIG;
	localparam logic [1:0] SK = csie_pkg::SP_SOCKET;
	localparam logic [7:0] FL = csie_pkg::LEG_FLAG_OFS;
	localparam logic [7:0] MK = csie_pkg::LEG_MASK_OFS;
	localparam logic [7:0] EV = csie_pkg::SOCK_EVT_OFS;
	localparam logic [7:0] SM = csie_pkg::SOCK_MASK_OFS;
	localparam logic [7:0] FS = csie_pkg::FUNC_STAT_OFS;
	localparam logic [7:0] RT = csie_pkg::ROUTE_OFS;

	logic        ref_clk;
	logic        sys_rst;
	logic        pwr_done;
	logic [1:0]  reg_space;
	logic [7:0]  reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic        reg_ack;
	logic [6:0]  mf_term;
	logic [1:0]  card_type;
	logic [4:0]  pins;
	int          err_count;
	int          cmp_count;
	int          ser_high;

	csie_top i_dut (
		.REF_CLK             (ref_clk),
		.SYS_RST             (sys_rst),
		.PIN_CARD_TYPE       (card_type),
		.PIN_STAT_BATT_ONE   (pins[0]),
		.PIN_SPKR_BATT_TWO   (pins[1]),
		.PIN_IRQ_READY       (pins[2]),
		.PIN_CARD_DETECT_ONE (pins[3]),
		.PIN_CARD_DETECT_TWO (pins[4]),
		.POWER_CYCLE_DONE    (pwr_done),
		.REG_SPACE           (reg_space),
		.REG_ADDR            (reg_addr),
		.REG_WR              (reg_wr),
		.REG_RD              (reg_rd),
		.REG_WDATA           (reg_wdata),
		.REG_RDATA           (reg_rdata),
		.REG_ACK             (reg_ack),
		.MF_TERM             (mf_term)
	);

	csie_card_model i_card (
		.clk       (ref_clk),
		.card_type (card_type),
		.pins      (pins)
	);

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
			err_count++;
		end
	endtask

	// The answer is registered on the taking edge itself, so it is settled
	// at the next falling edge, where the strobe is also dropped.
	task automatic reg_acc(input logic [1:0] sp, input logic [7:0] a,
			input logic w, input logic [31:0] d);
		@(negedge ref_clk);
		reg_space = sp;
		reg_addr  = a;
		reg_wdata = d;
		reg_wr    = w;
		reg_rd    = ~w;
		@(negedge ref_clk);
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		check({31'h0, reg_ack}, 32'h1);
	endtask

	task automatic rd_chk(input logic [1:0] sp, input logic [7:0] a,
			input logic [31:0] exp);
		reg_acc(sp, a, 1'b0, 32'h0);
		check(reg_rdata, exp);
	endtask

	task automatic wt(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic term_chk(input logic [6:0] exp);
		wt(4);
		check({25'h0, mf_term}, {25'h0, exp});
	endtask

	task automatic pwr_pulse();
		@(negedge ref_clk);
		pwr_done = 1'b1;
		@(negedge ref_clk);
		pwr_done = 1'b0;
		wt(3);
	endtask

	task automatic stop_test();
		$display("checks=%0d errors=%0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Clock and watchdog
	// ----------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// The sequence needs about eight hundred cycles; twenty-five times that is a hang.
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		stop_test();
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		err_count = 0;
		cmp_count = 0;
		sys_rst = 1'b1;
		pwr_done = 1'b0;
		{reg_wr, reg_rd, reg_space, reg_addr, reg_wdata} = '0;
		wt(8);
		sys_rst = 1'b0;
		rd_chk(LG, FL, 32'h0);
		rd_chk(LG, MK, 32'h0);
		rd_chk(CF, RT, 32'h1);
		rd_chk(SK, EV, 32'h0);
		reg_acc(2'h3, 8'h00, 1'b1, 32'hffff_ffff);
		rd_chk(2'h3, 8'h00, 32'h0);
		// Memory card: battery, ready and power events on legacy flags.
		i_card.insert(csie_pkg::CARD_MEM16);
		i_card.drive(0, 1'b1);
		term_chk(7'h00);
		rd_chk(LG, FL, 32'h1);
		rd_chk(LG, FL, 32'h0);
		i_card.drive(1, 1'b1);
		i_card.drive(2, 1'b1);
		term_chk(7'h00);
		rd_chk(CF, FS, 32'h0);
		rd_chk(LG, FL, 32'h6);
		i_card.drive(0, 1'b0);
		wt(3);
		rd_chk(LG, FL, 32'h1);
		reg_acc(LG, MK, 1'b1, 32'h1);
		i_card.drive(0, 1'b1);
		term_chk(7'h01);
		rd_chk(LG, FL, 32'h1);
		term_chk(7'h00);
		pwr_pulse();
		rd_chk(SK, EV, 32'h0);
		rd_chk(LG, FL, 32'h8);
		// Write-one clear mode: reads leave flags, zeros leave flags.
		reg_acc(LG, csie_pkg::LEG_GCTRL_OFS, 1'b1, 32'h4);
		rd_chk(LG, csie_pkg::LEG_GCTRL_OFS, 32'h4);
		i_card.drive(1, 1'b0);
		wt(3);
		rd_chk(LG, FL, 32'h2);
		rd_chk(LG, FL, 32'h2);
		reg_acc(LG, FL, 1'b1, 32'h0);
		rd_chk(LG, FL, 32'h2);
		reg_acc(LG, FL, 1'b1, 32'h2);
		rd_chk(LG, FL, 32'h0);
		// I/O card: status on assertion only, request never masked.
		i_card.drive(0, 1'b0);
		i_card.drive(2, 1'b0);
		i_card.insert(csie_pkg::CARD_IO16);
		reg_acc(LG, MK, 1'b1, 32'h0);
		reg_acc(LG, FL, 1'b1, 32'hf);
		i_card.drive(0, 1'b1);
		wt(3);
		rd_chk(LG, FL, 32'h1);
		reg_acc(LG, FL, 1'b1, 32'h1);
		i_card.drive(0, 1'b0);
		i_card.drive(1, 1'b1);
		wt(3);
		rd_chk(LG, FL, 32'h0);
		i_card.drive(2, 1'b1);
		term_chk(7'h01);
		rd_chk(CF, FS, 32'h1);
		i_card.drive(2, 1'b0);
		term_chk(7'h00);
		// Bus card: socket events, detect, power and write-one clear.
		i_card.insert(csie_pkg::CARD_CB32);
		i_card.drive(0, 1'b1);
		wt(3);
		rd_chk(LG, FL, 32'h0);
		rd_chk(SK, EV, 32'h1);
		i_card.drive(3, 1'b1);
		i_card.drive(4, 1'b1);
		pwr_pulse();
		rd_chk(SK, EV, 32'hf);
		term_chk(7'h00);
		reg_acc(SK, EV, 1'b1, 32'h0);
		rd_chk(SK, EV, 32'hf);
		reg_acc(SK, SM, 1'b1, 32'h2);
		rd_chk(SK, SM, 32'h2);
		term_chk(7'h01);
		reg_acc(SK, EV, 1'b1, 32'hf);
		rd_chk(SK, EV, 32'h0);
		term_chk(7'h00);
		i_card.drive(2, 1'b1);
		term_chk(7'h01);
		rd_chk(CF, FS, 32'h1);
		// Parallel IRQ lines: csc on terminal 3, functional on 5.
		reg_acc(CF, RT, 1'b1, 32'h0000_0532);
		rd_chk(CF, RT, 32'h0000_0532);
		term_chk(7'h20);
		i_card.drive(2, 1'b0);
		i_card.drive(3, 1'b0);
		term_chk(7'h08);
		// Serial frames: start slot plus IRQ 5 slot, 18 slots per frame.
		reg_acc(CF, RT, 1'b1, 32'h0005_0774);
		wt(300);
		ser_high = 0;
		repeat (288) begin
			@(negedge ref_clk);
			ser_high += mf_term[6];
		end
		check(ser_high, 32);
		stop_test();
	end
endmodule // tb_top
